// ---- sss_pkg.sv ----
// Contract
// - wrap flag sets when edge count rolls from 15 to 0
// - wrap request raised while wrap flag, wrap enable and global enable set
// - wrap flag clears only on written one; clearing releases wrap clock hold
// - wrap request also drives the idle wake output
// - stop flag sets on stop in two-wire mode; write one clears; no request
// - mismatch bit reads one when shift bit 7 differs from data pin
// - edge count sits in status bits 3:0, readable and writable anytime
// - edge count increments once per strobe or timer clock, and on both clock-pin edges for external source
// - external source with strobe bit set: each toggle write clocks the count
// - counter still clocked from the clock pin with outputs disabled
// - start enable gates start request; pending flag requests at once
// - wrap enable gates wrap request; pending flag requests at once
// - wire select in control bits 5:4 changes output behaviour and start and stop detection
// - wire select zero: pins follow port bits, clock hold and start detector off
// - three-wire: shift bit 7 overrides port bit; direction bit still rules
// - two-wire: both lines open-collector, enabled by their direction bits
// - data line pulled low when shift top bit or port bit is zero
// - clock line low when port bit zero or held after detected start
// - pull-ups on both lines disabled in two-wire modes
// - select 11: clock line also held low after wrap until flag cleared
// - start flag sets on start in two-wire; write one clears, releases hold
// - source select zero: strobe bit write clocks shift register and counter
package sss_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int REG_W  = 8;
  localparam int CNT_W  = 4;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_SHIFT   = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PORT    = 12'h00c;

  localparam logic [REG_W-1:0] CONTROL_RESET = 8'h00;
  localparam logic [REG_W-1:0] SHIFT_RESET   = 8'h00;
  localparam logic [REG_W-1:0] PORT_RESET    = 8'h00;
  localparam logic [CNT_W-1:0] COUNT_RESET   = 4'h0;
  localparam logic [CNT_W-1:0] COUNT_MAX     = 4'hf;
  localparam logic [CNT_W-1:0] COUNT_STEP    = 4'h1;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int ST_START    = 7;
  localparam int ST_WRAP     = 6;
  localparam int ST_STOP     = 5;
  localparam int ST_MISMATCH = 4;
  localparam int ST_CNT_MSB  = 3;
  localparam int ST_CNT_LSB  = 0;

  localparam int CT_SIE    = 7;
  localparam int CT_OIE    = 6;
  localparam int CT_WM_MSB = 5;
  localparam int CT_WM_LSB = 4;
  localparam int CT_CS_MSB = 3;
  localparam int CT_CS_LSB = 2;
  localparam int CT_STROBE = 1;
  localparam int CT_TOGGLE = 0;

  localparam int PT_SDA     = 0;
  localparam int PT_SCL     = 1;
  localparam int PT_DO      = 2;
  localparam int PT_SDA_DIR = 4;
  localparam int PT_SCL_DIR = 5;
  localparam int PT_DO_DIR  = 6;
  localparam int SHIFT_MSB  = 7;

  // ************************************************************
  // modes
  // ************************************************************
  localparam logic [1:0] WM_OFF      = 2'h0;
  localparam logic [1:0] WM_THREE    = 2'h1;
  localparam logic [1:0] WM_TWO      = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  localparam logic [1:0] CS_STROBE  = 2'h0;
  localparam logic [1:0] CS_TIMER   = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;
endpackage

// ---- sss_line_if.sv ----
interface sss_line_if;
  logic sda;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic two_wire;
  logic start_det;
  logic stop_det;

  modport sync (output sda, scl, scl_rise, scl_fall, sda_rise, sda_fall);
  modport detect (input sda, scl, sda_rise, sda_fall, two_wire,
                  output start_det, stop_det);
  modport core (input sda, scl, scl_rise, scl_fall, start_det, stop_det,
                output two_wire);
endinterface

// ---- sss_line_sync.sv ----
module sss_line_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sda_in,
  input  wire logic scl_in,
  sss_line_if.sync  lines
);
  import sss_pkg::*;

  // ************************************************************
  // two-stage synchronisers, third stage for edges
  // ************************************************************
  logic [1:0] sda_meta;
  logic [1:0] scl_meta;
  logic       sda_last;
  logic       scl_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_meta <= 2'h3;
      scl_meta <= 2'h3;
      sda_last <= 1'b1;
      scl_last <= 1'b1;
    end else begin
      sda_meta <= {sda_meta[0], sda_in};
      scl_meta <= {scl_meta[0], scl_in};
      sda_last <= sda_meta[1];
      scl_last <= scl_meta[1];
    end
  end

  assign lines.sda      = sda_meta[1];
  assign lines.scl      = scl_meta[1];
  assign lines.sda_rise = sda_meta[1] & ~sda_last;
  assign lines.sda_fall = ~sda_meta[1] & sda_last;
  assign lines.scl_rise = scl_meta[1] & ~scl_last;
  assign lines.scl_fall = ~scl_meta[1] & scl_last;
endmodule

// ---- sss_cond_detect.sv ----
module sss_cond_detect (
  sss_line_if.detect lines
);
  import sss_pkg::*;

  // ************************************************************
  // start and stop seen only while clock is high in two-wire mode
  // ************************************************************
  // the sda and scl paths have equal stages, so scl is sampled in the cycle of the data edge
  assign lines.start_det = lines.two_wire & lines.scl & lines.sda_fall;
  assign lines.stop_det  = lines.two_wire & lines.scl & lines.sda_rise;
endmodule

// ---- sss_top.sv ----
// Added by the designer: the APB slave port and the placing of the registers.
module sss_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [sss_pkg::ADDR_W-1:0] paddr,
  input  wire logic [sss_pkg::DATA_W-1:0] pwdata,
  output logic      [sss_pkg::DATA_W-1:0] prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      timer_match,
  input  wire logic                      global_irq_enable,
  input  wire logic                      sda_in,
  input  wire logic                      scl_in,
  output logic                           do_out,
  output logic                           do_oe_n,
  output logic                           do_pullup,
  output logic                           sda_out,
  output logic                           sda_oe_n,
  output logic                           sda_pullup,
  output logic                           scl_out,
  output logic                           scl_oe_n,
  output logic                           scl_pullup,
  output logic                           start_irq,
  output logic                           wrap_irq,
  output logic                           idle_wake
);
  import sss_pkg::*;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic is_two_wire(input logic [1:0] mode);
    is_two_wire = (mode == WM_TWO) | (mode == WM_TWO_HOLD);
  endfunction

  function automatic logic is_external(input logic [1:0] src);
    is_external = (src == CS_EXT_POS) | (src == CS_EXT_NEG);
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  logic             start_ie;
  logic             wrap_ie;
  logic [1:0]       wire_select;
  logic [1:0]       clock_source_select;
  logic             toggle_clocks_count;
  logic             start_seen_flag;
  logic             counter_wrap_flag;
  logic             stop_seen_flag;
  logic [CNT_W-1:0] edge_count;
  logic [REG_W-1:0] shift_data;
  logic [REG_W-1:0] port_reg;
  logic             start_hold;

  sss_line_if lines ();

  sss_line_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .sda_in  (sda_in),
    .scl_in  (scl_in),
    .lines   (lines)
  );

  sss_cond_detect u_detect (
    .lines (lines)
  );

  // ************************************************************
  // bus decode
  // ************************************************************
  wire             setup_phase = psel & ~penable;
  wire             access_done = psel & penable & pready;
  wire             bus_write   = access_done & pwrite;
  wire             hit_status  = paddr == OFF_STATUS;
  wire             hit_control = paddr == OFF_CONTROL;
  wire             hit_shift   = paddr == OFF_SHIFT;
  wire             hit_port    = paddr == OFF_PORT;
  wire             hit_any     = hit_status | hit_control | hit_shift | hit_port;
  wire [REG_W-1:0] wbyte       = pwdata[REG_W-1:0];
  wire             wr_status   = bus_write & hit_status;
  wire             wr_control  = bus_write & hit_control;
  wire             wr_shift    = bus_write & hit_shift;
  wire             wr_port     = bus_write & hit_port;

  // control values as they stand after this cycle's write; two_wire still uses the registered wire select
  wire [1:0] eff_source = wr_control ? wbyte[CT_CS_MSB:CT_CS_LSB] : clock_source_select;
  wire       eff_tsel   = wr_control ? wbyte[CT_STROBE] : toggle_clocks_count;
  wire       strobe_wr  = wr_control & wbyte[CT_STROBE];
  wire       toggle_wr  = wr_control & wbyte[CT_TOGGLE];
  wire       two_wire   = is_two_wire(wire_select);
  wire       ext_src    = is_external(eff_source);

  assign lines.two_wire = two_wire;

  // ************************************************************
  // clock sources
  // ************************************************************
  // inputs are never gated by wire select, so counting works with outputs off
  wire scl_edge  = lines.scl_rise | lines.scl_fall;
  wire count_inc = ((eff_source == CS_STROBE) & strobe_wr)
                 | ((eff_source == CS_TIMER) & timer_match)
                 | (ext_src & ~eff_tsel & scl_edge)
                 | (ext_src & eff_tsel & toggle_wr);
  wire shift_en  = ((eff_source == CS_STROBE) & strobe_wr)
                 | ((eff_source == CS_TIMER) & timer_match)
                 | ((eff_source == CS_EXT_POS) & lines.scl_rise)
                 | ((eff_source == CS_EXT_NEG) & lines.scl_fall);

  // ************************************************************
  // counter and flags
  // ************************************************************
  // a software load of the count beats an increment in the same cycle
  wire wrap_event = count_inc & ~wr_status & (edge_count == COUNT_MAX);
  wire [CNT_W-1:0] next_edge_count =
    wr_status ? wbyte[ST_CNT_MSB:ST_CNT_LSB] :
    count_inc ? edge_count + COUNT_STEP : edge_count;

  wire start_event = lines.start_det
                   | (~two_wire & ext_src & ~eff_tsel & scl_edge);
  wire clr_start   = wr_status & wbyte[ST_START];
  wire clr_wrap    = wr_status & wbyte[ST_WRAP];
  wire clr_stop    = wr_status & wbyte[ST_STOP];

  // set wins over clear so an event in the clearing cycle survives
  wire next_start_flag = start_event | (start_seen_flag & ~clr_start);
  wire next_wrap_flag  = wrap_event | (counter_wrap_flag & ~clr_wrap);
  wire next_stop_flag  = lines.stop_det | (stop_seen_flag & ~clr_stop);

  // hold begins at the first clock fall after the start, ends with the flag
  wire next_start_hold = next_start_flag
                       & (start_hold | (start_seen_flag & two_wire & lines.scl_fall));
  wire wrap_hold       = (wire_select == WM_TWO_HOLD) & counter_wrap_flag;

  wire [REG_W-1:0] next_shift =
    wr_shift ? wbyte :
    shift_en ? {shift_data[REG_W-2:0], lines.sda} : shift_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_count        <= COUNT_RESET;
      start_seen_flag   <= 1'b0;
      counter_wrap_flag <= 1'b0;
      stop_seen_flag    <= 1'b0;
      start_hold        <= 1'b0;
      shift_data        <= SHIFT_RESET;
    end else begin
      edge_count        <= next_edge_count;
      start_seen_flag   <= next_start_flag;
      counter_wrap_flag <= next_wrap_flag;
      stop_seen_flag    <= next_stop_flag;
      start_hold        <= next_start_hold;
      shift_data        <= next_shift;
    end
  end

  // ************************************************************
  // control and port registers
  // ************************************************************
  // the toggle bit flips the clock port bit whatever its direction
  wire [REG_W-1:0] port_toggled = port_reg ^ (REG_W'(toggle_wr) << PT_SCL);
  wire [REG_W-1:0] next_port    = wr_port ? wbyte : port_toggled;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_ie            <= CONTROL_RESET[CT_SIE];
      wrap_ie             <= CONTROL_RESET[CT_OIE];
      wire_select         <= CONTROL_RESET[CT_WM_MSB:CT_WM_LSB];
      clock_source_select <= CONTROL_RESET[CT_CS_MSB:CT_CS_LSB];
      toggle_clocks_count <= CONTROL_RESET[CT_STROBE];
      port_reg            <= PORT_RESET;
    end else begin
      if (wr_control) begin
        start_ie            <= wbyte[CT_SIE];
        wrap_ie             <= wbyte[CT_OIE];
        wire_select         <= wbyte[CT_WM_MSB:CT_WM_LSB];
        clock_source_select <= wbyte[CT_CS_MSB:CT_CS_LSB];
        toggle_clocks_count <= wbyte[CT_STROBE];
      end
      port_reg <= next_port;
    end
  end

  // ************************************************************
  // pin drive
  // ************************************************************
  wire sda_dir = port_reg[PT_SDA_DIR];
  wire scl_dir = port_reg[PT_SCL_DIR];
  wire do_dir  = port_reg[PT_DO_DIR];
  wire top_bit = shift_data[SHIFT_MSB];

  // output latch transparency is not modelled: bit 7 reaches the pin one cycle later, through the output flop
  wire do_val     = (wire_select == WM_THREE) ? top_bit : port_reg[PT_DO];
  wire do_oe_val  = do_dir;
  wire do_pu_val  = ~do_dir & port_reg[PT_DO];

  wire sda_low    = sda_dir & (~top_bit | ~port_reg[PT_SDA]);
  wire scl_low    = scl_dir & (~port_reg[PT_SCL] | start_hold | wrap_hold);
  wire sda_val    = two_wire ? 1'b0 : port_reg[PT_SDA];
  wire scl_val    = two_wire ? 1'b0 : port_reg[PT_SCL];
  wire sda_oe_val = two_wire ? sda_low : sda_dir;
  wire scl_oe_val = two_wire ? scl_low : scl_dir;
  wire sda_pu_val = ~two_wire & ~sda_dir & port_reg[PT_SDA];
  wire scl_pu_val = ~two_wire & ~scl_dir & port_reg[PT_SCL];

  // ************************************************************
  // requests
  // ************************************************************
  // a flag left pending raises its request as soon as the enables are set
  wire start_req = start_seen_flag & start_ie & global_irq_enable;
  wire wrap_req  = counter_wrap_flag & wrap_ie & global_irq_enable;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_out     <= 1'b0;
      do_oe_n    <= 1'b1;
      do_pullup  <= 1'b0;
      sda_out    <= 1'b0;
      sda_oe_n   <= 1'b1;
      sda_pullup <= 1'b0;
      scl_out    <= 1'b0;
      scl_oe_n   <= 1'b1;
      scl_pullup <= 1'b0;
      start_irq  <= 1'b0;
      wrap_irq   <= 1'b0;
      idle_wake  <= 1'b0;
    end else begin
      do_out     <= do_val;
      do_oe_n    <= ~do_oe_val;
      do_pullup  <= do_pu_val;
      sda_out    <= sda_val;
      sda_oe_n   <= ~sda_oe_val;
      sda_pullup <= sda_pu_val;
      scl_out    <= scl_val;
      scl_oe_n   <= ~scl_oe_val;
      scl_pullup <= scl_pu_val;
      start_irq  <= start_req;
      wrap_irq   <= wrap_req;
      idle_wake  <= wrap_req;
    end
  end

  // ************************************************************
  // read path and bus answer
  // ************************************************************
  wire mismatch = top_bit ^ lines.sda;
  wire [REG_W-1:0] status_rd  = {start_seen_flag, counter_wrap_flag, stop_seen_flag,
                                 mismatch, edge_count};
  // strobe and toggle bits always read back as zero
  wire [REG_W-1:0] control_rd = {start_ie, wrap_ie, wire_select, clock_source_select,
                                 2'h0};
  wire [REG_W-1:0] read_byte  = hit_status  ? status_rd  :
                                hit_control ? control_rd :
                                hit_shift   ? shift_data :
                                hit_port    ? port_reg   : {REG_W{1'b0}};

  // registering the answer in the setup cycle gives no wait state and keeps the read mux off the bus output path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= {DATA_W{1'b0}};
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= {{(DATA_W-REG_W){1'b0}}, read_byte};
      pready  <= 1'b1;
      pslverr <= ~hit_any;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule

// ---- sss_asserts.sv ----
module sss_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        global_irq_enable,
  input wire logic        start_irq,
  input wire logic        wrap_irq,
  input wire logic        idle_wake,
  input wire logic        sda_oe_n,
  input wire logic        sda_pullup,
  input wire logic        scl_oe_n,
  input wire logic        scl_pullup
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ********
  // checks
  // ********
  a_wake_tracks_wrap: assert property (idle_wake == wrap_irq)
    else $error("idle wake differs from wrap request");
  a_wrap_needs_global: assert property ($rose(wrap_irq) |-> $past(global_irq_enable))
    else $error("wrap request rose without global enable");
  a_start_needs_global: assert property ($rose(start_irq) |-> $past(global_irq_enable))
    else $error("start request rose without global enable");
  a_global_off_quiet: assert property (!global_irq_enable |=> !wrap_irq && !start_irq)
    else $error("request stayed up with global enable off");
  // a flag clears only by a bus write, so a request may only fall after one or with global enable off
  a_wrap_clear_write: assert property ($fell(wrap_irq) |->
    $past(!global_irq_enable) || $past(psel && penable && pwrite, 2))
    else $error("wrap request fell with no write");
  a_start_clear_write: assert property ($fell(start_irq) |->
    $past(!global_irq_enable) || $past(psel && penable && pwrite, 2))
    else $error("start request fell with no write");
  a_sda_pull_input: assert property (!sda_oe_n |-> !sda_pullup)
    else $error("data pull-up on while driving");
  a_scl_pull_input: assert property (!scl_oe_n |-> !scl_pullup)
    else $error("clock pull-up on while driving");
  a_read_upper_zero: assert property (pready |-> prdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  c_wrap_seen: cover property ($rose(wrap_irq));
  c_start_seen: cover property ($rose(start_irq));
  c_scl_held: cover property ($fell(scl_oe_n) && !scl_pullup);
endmodule

// ---- sss_remote.sv ----
module sss_remote (
  input  wire logic sda_out,
  input  wire logic sda_oe_n,
  input  wire logic scl_out,
  input  wire logic scl_oe_n,
  output wire logic sda_line,
  output wire logic scl_line
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sda_low = 1'b0;
  logic scl_low = 1'b0;
  // ********
  // bus lines with pull-ups: wired-and of both parties
  // ********
  assign sda_line = (sda_oe_n | sda_out) & !sda_low;
  assign scl_line = (scl_oe_n | scl_out) & !scl_low;
  // the device may stretch a released clock, so wait, but not forever
  task automatic wait_high();
    int n;
    n = 0;
    while (scl_line !== 1'b1 && n < 400) begin
      #10;
      n++;
    end
  endtask
  // step off the system clock edge so the pins never race the sampling flops
  task automatic pulses(input int n);
    #1;
    repeat (n) begin
      scl_low = 1'b1;
      #62.5;
      scl_low = 1'b0;
      wait_high();
      #62.5;
    end
  endtask
  task automatic start_cond();
    #1;
    sda_low = 1'b1;
    #62.5;
    scl_low = 1'b1;
    #62.5;
  endtask
  task automatic stop_cond();
    #1;
    scl_low = 1'b0;
    wait_high();
    #62.5;
    sda_low = 1'b0;
    #62.5;
  endtask
endmodule

// ---- serial_shift_status_control_test.sv ----
module serial_shift_status_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  import sss_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, timer_match, global_irq_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, do_out, do_oe_n, do_pullup, sda_out, sda_oe_n;
  logic        sda_pullup, scl_out, scl_oe_n, scl_pullup, start_irq, wrap_irq, idle_wake;
  wire         sda_line, scl_line;
  logic [32:0] expq[$];
  int          mismatches, checks, seed, k;
  sss_top u_sss_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_match(timer_match), .global_irq_enable(global_irq_enable), .sda_in(sda_line),
    .scl_in(scl_line), .do_out(do_out), .do_oe_n(do_oe_n), .do_pullup(do_pullup),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sda_pullup(sda_pullup), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .scl_pullup(scl_pullup), .start_irq(start_irq),
    .wrap_irq(wrap_irq), .idle_wake(idle_wake));
  sss_remote u_sss_remote (.sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_out(scl_out),
    .scl_oe_n(scl_oe_n), .sda_line(sda_line), .scl_line(scl_line));
  // ********
  // helpers
  // ********
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h000000, d});
  endtask
  // a read notes {error, data} first; the watcher below compares on pready
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expq.push_back(e);
    xfer(1'b0, a, 32'h00000000);
  endtask
  task automatic settle();
    repeat (4) @(posedge pclk);
  endtask
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0)
      check("read", {pslverr, prdata}, expq.pop_front());
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #500000;
    mismatches++;
    complete_run();
  end
  // ********
  // scenarios
  // ********
  initial begin
    {presetn, psel, penable, pwrite, timer_match} = 5'h00;
    {paddr, pwdata, global_irq_enable, seed} = {44'h0, 1'b1, 32'd51};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFF_STATUS, 33'h10);
    rd(OFF_CONTROL, 33'h00);
    rd(12'h010, 33'h100000000);
    check("do_oe_n", do_oe_n, 1'b1);
    wr(OFF_SHIFT, 8'hff);
    wr(OFF_STATUS, 8'h0e);
    wr(OFF_CONTROL, 8'h42);
    rd(OFF_STATUS, 33'h0f);
    wr(OFF_CONTROL, 8'h42);
    rd(OFF_STATUS, 33'h40);
    check("wrap_irq", wrap_irq, 1'b1);
    check("idle_wake", idle_wake, 1'b1);
    global_irq_enable <= 1'b0;
    settle();
    check("wrap_irq", wrap_irq, 1'b0);
    global_irq_enable <= 1'b1;
    settle();
    check("wrap_irq", wrap_irq, 1'b1);
    wr(OFF_STATUS, 8'h05);
    rd(OFF_STATUS, 33'h45);
    wr(OFF_STATUS, 8'h40);
    rd(OFF_STATUS, 33'h00);
    wr(OFF_CONTROL, 8'h04);
    k = ($random(seed) & 7) + 1;
    repeat (k) begin
      @(posedge pclk);
      timer_match <= 1'b1;
      @(posedge pclk);
      timer_match <= 1'b0;
    end
    rd(OFF_STATUS, 33'(k));
    wr(OFF_CONTROL, 8'h0a);
    wr(OFF_CONTROL, 8'h0b);
    wr(OFF_CONTROL, 8'h0b);
    rd(OFF_STATUS, 33'(k + 2));
    wr(OFF_STATUS, 8'h00);
    wr(OFF_CONTROL, 8'h08);
    u_sss_remote.pulses(2);
    settle();
    rd(OFF_STATUS, 33'h84);
    check("scl_oe_n", scl_oe_n, 1'b1);
    wr(OFF_STATUS, 8'h80);
    wr(OFF_PORT, 8'h33);
    wr(OFF_CONTROL, 8'ha0);
    settle();
    check("sda_pullup", sda_pullup, 1'b0);
    check("sda_oe_n", sda_oe_n, 1'b1);
    check("line out", {sda_out, scl_out, scl_pullup}, 3'h0);
    // driving a zero with the clock high is itself a start, then a stop
    wr(OFF_SHIFT, 8'h7f);
    settle();
    check("sda_oe_n", sda_oe_n, 1'b0);
    wr(OFF_SHIFT, 8'hff);
    settle();
    rd(OFF_STATUS, 33'ha0);
    check("start_irq", start_irq, 1'b1);
    wr(OFF_STATUS, 8'he0);
    u_sss_remote.start_cond();
    settle();
    check("scl_oe_n", scl_oe_n, 1'b0);
    rd(OFF_STATUS, 33'h90);
    wr(OFF_STATUS, 8'h80);
    settle();
    check("scl_oe_n", scl_oe_n, 1'b1);
    u_sss_remote.stop_cond();
    settle();
    rd(OFF_STATUS, 33'h20);
    check("start_irq", start_irq, 1'b0);
    wr(OFF_STATUS, 8'h2f);
    wr(OFF_CONTROL, 8'h32);
    settle();
    check("scl_oe_n", scl_oe_n, 1'b0);
    wr(OFF_STATUS, 8'h40);
    settle();
    check("scl_oe_n", scl_oe_n, 1'b1);
    wr(OFF_CONTROL, 8'h10);
    wr(OFF_PORT, 8'h40);
    settle();
    check("do_out", {do_out, do_oe_n}, 2'b10);
    wr(OFF_PORT, 8'h04);
    settle();
    check("do_pullup", {do_oe_n, do_pullup}, 2'b11);
    // second reset in mid-run: outputs and control fall back to idle
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    check("do_pullup", do_pullup, 1'b0);
    rd(OFF_CONTROL, 33'h00);
    wr(OFF_PORT, 8'h03);
    settle();
    check("port pins", {sda_out, sda_pullup, scl_out, scl_pullup}, 4'hf);
    complete_run();
  end
endmodule
bind sss_top sss_asserts u_sss_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
  .global_irq_enable(global_irq_enable), .start_irq(start_irq), .wrap_irq(wrap_irq),
  .idle_wake(idle_wake), .sda_oe_n(sda_oe_n), .sda_pullup(sda_pullup),
  .scl_oe_n(scl_oe_n), .scl_pullup(scl_pullup));
